// ===== design/alc_unit.sv
// Accumulator logic and compare unit: holds the accumulator and flags.
// Assumes the sequencer drives requests synchronously to core_clk and the
// word memory returns data the cycle after a read enable.

module alc_unit
  import alc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Operation request from the sequencer
  input wire logic op_valid,
  input wire alc_req_t op_req,
  output logic op_ready,
  output logic op_done,
  // Direct accumulator load
  input wire logic acc_load_en,
  input wire logic [ACC_W-1:0] acc_load_data,
  // Word memory read port
  output logic mem_rd_en,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [WORD_W-1:0] mem_rd_data,
  // Results
  output logic [ACC_W-1:0] acc_value,
  output alc_flags_t flags
);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD_LO,
    ST_RD_HI,
    ST_EXEC
  } alc_state_t;

  alc_state_t state_reg, state_next;  // Control state
  alc_req_t req_reg, req_next;        // Latched request
  logic [WORD_W-1:0] lo_reg, lo_next; // Low operand word
  logic rd_en_reg, rd_en_next;        // Memory read strobe
  logic [ADDR_W-1:0] addr_reg, addr_next; // Memory address
  logic done_reg, done_next;          // Completion pulse
  logic take;                         // Request accepted this cycle
  logic dbl;                          // Latched op is double width

  assign op_ready = (state_reg == ST_IDLE);
  assign take = op_valid && op_ready;
  assign dbl = alc_is_double(req_reg.op);

  // Next state and memory fetch sequencing
  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    lo_next = lo_reg;
    rd_en_next = 1'b0;
    addr_next = addr_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          req_next = op_req;
          if (op_req.use_const) begin
            // Constant operand needs no fetch
            state_next = ST_EXEC;
          end else begin
            // Low word first, at the given address
            rd_en_next = 1'b1;
            addr_next = op_req.addr;
            state_next = ST_RD_LO;
          end
        end
      end
      ST_RD_LO: begin
        if (dbl) begin
          // Second word of the pair follows directly
          rd_en_next = 1'b1;
          addr_next = addr_reg + HI_WORD_OFS;
          state_next = ST_RD_HI;
        end else begin
          state_next = ST_EXEC;
        end
      end
      ST_RD_HI: begin
        // Low word is on the data bus now
        lo_next = mem_rd_data;
        state_next = ST_EXEC;
      end
      ST_EXEC: begin
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
      lo_reg <= WORD_RST;
      rd_en_reg <= 1'b0;
      addr_reg <= ADDR_RST;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      lo_reg <= lo_next;
      rd_en_reg <= rd_en_next;
      addr_reg <= addr_next;
      done_reg <= done_next;
    end
  end

  assign mem_rd_en = rd_en_reg;
  assign mem_addr = addr_reg;
  assign op_done = done_reg;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] acc_reg, acc_next; // Accumulator
  alc_flags_t flags_reg, flags_next;   // Status flags
  logic [ACC_W-1:0] opnd;              // Effective operand
  logic [ACC_W-1:0] res;               // Logical result
  logic [ACC_W-1:0] acc_lo;            // Low half, zero-extended

  // Operand: constant, word pair (low word first), or single word
  always_comb begin
    if (req_reg.use_const) begin
      opnd = dbl ? req_reg.konst : {UPPER_CLR, req_reg.konst[15:0]};
    end else if (dbl) begin
      opnd = {mem_rd_data, lo_reg};
    end else begin
      opnd = {UPPER_CLR, mem_rd_data};
    end
  end

  assign acc_lo = {UPPER_CLR, acc_reg[15:0]};

  // Result and flags computed together, so both land on one edge
  always_comb begin
    acc_next = acc_reg;
    flags_next = flags_reg;
    res = acc_reg;
    if (state_reg == ST_EXEC) begin
      case (req_reg.op)
        and_double_op: begin
          res = acc_reg & opnd;
        end
        or_single_op: begin
          res = acc_lo | opnd;
        end
        or_double_op: begin
          res = acc_reg | opnd;
        end
        xor_single_op: begin
          res = acc_lo ^ opnd;
        end
        xor_double_op: begin
          res = acc_reg ^ opnd;
        end
        default: begin
          res = acc_reg;
        end
      endcase
      case (req_reg.op)
        and_double_op, or_double_op, xor_double_op: begin
          acc_next = res;
          flags_next.zero_result_flag = (res == ACC_RST);
          flags_next.negative_flag = res[ACC_W-1];
        end
        or_single_op, xor_single_op: begin
          acc_next = res;
          flags_next.zero_result_flag = (res == ACC_RST);
          // Second flag follows the zero result here, not the sign
          flags_next.negative_flag = (res == ACC_RST);
        end
        compare_single: begin
          // Greater flag is left alone; only less and equal move
          flags_next.less_than_flag = (acc_lo < opnd);
          flags_next.equal_flag = (acc_lo == opnd);
        end
        compare_double: begin
          flags_next.less_than_flag = (acc_reg < opnd);
          flags_next.equal_flag = (acc_reg == opnd);
          flags_next.greater_than_flag = (acc_reg > opnd);
        end
        default: begin
          // Unused code: completes with no effect
          acc_next = acc_reg;
        end
      endcase
    end else if (acc_load_en && op_ready && !op_valid) begin
      // Direct load only when idle and no operation competes
      acc_next = acc_load_data;
    end
  end

  // Datapath registers; flags change only through flags_next above
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= ACC_RST;
      flags_reg <= alc_flags_t'(FLAGS_RST);
    end else begin
      acc_reg <= acc_next;
      flags_reg <= flags_next;
    end
  end

  assign acc_value = acc_reg;
  assign flags = flags_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Operand as seen in the execute cycle, one cycle back
  logic exec_q;
  logic [ACC_W-1:0] opnd_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exec_q <= 1'b0;
      opnd_q <= ACC_RST;
    end else begin
      exec_q <= (state_reg == ST_EXEC);
      opnd_q <= opnd;
    end
  end

  a_and_double_res: assert property (
    done_reg && req_reg.op == and_double_op |->
      acc_reg == ($past(acc_reg) & opnd_q))
    else $error("and double result wrong");

  a_or_single_res: assert property (
    done_reg && req_reg.op == or_single_op |->
      acc_reg == ({UPPER_CLR, $past(acc_reg[15:0])} | opnd_q))
    else $error("or single result wrong");

  a_or_double_res: assert property (
    done_reg && req_reg.op == or_double_op |->
      acc_reg == ($past(acc_reg) | opnd_q))
    else $error("or double result wrong");

  a_xor_single_res: assert property (
    done_reg && req_reg.op == xor_single_op |->
      acc_reg == ({UPPER_CLR, $past(acc_reg[15:0])} ^ opnd_q))
    else $error("xor single result wrong");

  a_xor_double_res: assert property (
    done_reg && req_reg.op == xor_double_op |->
      acc_reg == ($past(acc_reg) ^ opnd_q))
    else $error("xor double result wrong");

  a_zero_flag_set: assert property (
    done_reg && req_reg.op inside {and_double_op, or_single_op,
      or_double_op, xor_single_op, xor_double_op} |->
      flags_reg.zero_result_flag == (acc_reg == ACC_RST))
    else $error("zero flag disagrees with accumulator");

  a_neg_flag_msb: assert property (
    done_reg && req_reg.op inside {and_double_op, or_double_op,
      xor_double_op} |-> flags_reg.negative_flag == acc_reg[ACC_W-1])
    else $error("negative flag disagrees with msb");

  a_neg_single_zero: assert property (
    done_reg && req_reg.op inside {or_single_op, xor_single_op} |->
      flags_reg.negative_flag == (acc_reg == ACC_RST))
    else $error("second flag wrong after single op");

  a_flags_hold_idle: assert property (
    state_reg != ST_EXEC |=> $stable(flags_reg))
    else $error("flags changed without an operation");

  a_comp_single_flags: assert property (
    done_reg && req_reg.op == compare_single |->
      flags_reg.less_than_flag == ($past(acc_lo) < opnd_q) &&
      flags_reg.equal_flag == ($past(acc_lo) == opnd_q) &&
      $stable(acc_reg) && $stable(flags_reg.greater_than_flag))
    else $error("single compare flags wrong");

  a_comp_double_less: assert property (
    done_reg && req_reg.op == compare_double |->
      flags_reg.less_than_flag == (acc_reg < opnd_q))
    else $error("double compare less flag wrong");

  a_comp_double_eq: assert property (
    done_reg && req_reg.op == compare_double |->
      flags_reg.equal_flag == (acc_reg == opnd_q))
    else $error("double compare equal flag wrong");

  a_comp_double_gt: assert property (
    done_reg && req_reg.op == compare_double |->
      flags_reg.greater_than_flag == (acc_reg > opnd_q))
    else $error("double compare greater flag wrong");

  a_done_with_update: assert property (
    take && op_req.use_const |=> ##1 done_reg && exec_q)
    else $error("constant op not done two cycles after take");

  a_mem_pair_fetch: assert property (
    take && !op_req.use_const && alc_is_double(op_req.op) |=>
      mem_rd_en && mem_addr == $past(op_req.addr) ##1
      mem_rd_en && mem_addr == $past(op_req.addr, 2) + HI_WORD_OFS
      ##2 done_reg)
    else $error("word pair fetch sequence wrong");

  c_or_double_const: cover property (
    take && op_req.use_const && op_req.op == or_double_op);
  c_comp_double_mem: cover property (
    take && !op_req.use_const && op_req.op == compare_double ##4 done_reg);
  c_xor_single_zero: cover property (
    done_reg && req_reg.op == xor_single_op && flags_reg.negative_flag);
  c_and_negative: cover property (
    done_reg && req_reg.op == and_double_op && flags_reg.negative_flag);

endmodule

// ===== design/alc_pkg.sv
// Shared types and constants of the accumulator logic and compare unit.
// Assumes one core clock domain and a synchronous-read word memory.

package alc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ACC_W = 32;   // Accumulator width
  localparam int WORD_W = 16;  // Word memory width
  localparam int ADDR_W = 16;  // Word memory address width

  // ----------------------------------------------------------------
  // Reset values and fixed offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] UPPER_CLR = 16'h0000;  // Single-width upper half
  localparam logic [15:0] HI_WORD_OFS = 16'h0001; // Second word of a pair
  localparam logic [4:0] FLAGS_RST = 5'h00;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    and_double_op,
    or_single_op,
    or_double_op,
    xor_single_op,
    xor_double_op,
    compare_single,
    compare_double
  } alc_op_t;

  // Request from the sequencer
  typedef struct packed {
    alc_op_t op;               // Operation
    logic use_const;           // Operand is the constant, not memory
    logic [ADDR_W-1:0] addr;   // First (low) memory word address
    logic [ACC_W-1:0] konst;   // Instruction constant
  } alc_req_t;

  // Status flags
  typedef struct packed {
    logic zero_result_flag;
    logic negative_flag;
    logic less_than_flag;
    logic equal_flag;
    logic greater_than_flag;
  } alc_flags_t;

  // Double-width operations take a 32-bit operand
  function automatic logic alc_is_double(input alc_op_t op);
    return (op == and_double_op) || (op == or_double_op) ||
           (op == xor_double_op) || (op == compare_double);
  endfunction

endpackage

// ===== tb/alc_word_mem.sv
// Word memory model that stands behind the unit's read port.
// Assumes reads are strobed on core_clk. A word is expected one cycle
// after its strobe.

module alc_word_mem
  import alc_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Read port
  input wire logic mem_rd_en,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  // Contents follow the address, so no preload path is needed.
  // The word holds until the next strobe, as single ops read it late.
  // Unknown until the first strobe; the unit never reads it before that
  always @(posedge core_clk) begin
    if (mem_rd_en) begin
      mem_rd_data <= {mem_addr[7:0], ~mem_addr[7:0]};
    end
  end
endmodule

// ===== tb/alc_unit_tb.sv
// Self-checking bench for the accumulator logic and compare unit.
// Assumes the word memory model answers one cycle after each strobe.

module alc_unit_tb
  import alc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // One ordinary case: stimulus beside the expected outcome
  typedef struct {
    alc_op_t op;
    bit uc;             // Constant operand instead of memory
    logic [31:0] opnd;  // Constant, or low word address
    logic [31:0] acc;   // Accumulator before the operation
    logic [31:0] ea;    // Expected accumulator
    logic [4:0] ef;     // Expected flags
  } alc_row_t;

  logic core_clk;
  logic sys_rst;
  logic op_valid;
  alc_req_t op_req;
  logic op_ready;
  logic op_done;
  logic acc_load_en;
  logic [ACC_W-1:0] acc_load_data;
  logic mem_rd_en;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_rd_data;
  logic [ACC_W-1:0] acc_value;
  alc_flags_t flags;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;     // Hang guard
  alc_row_t rows [14];
  alc_row_t r;

  // ----------------------------------------------------------------
  // Design and memory model
  // ----------------------------------------------------------------
  alc_unit u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_req(op_req), .op_ready(op_ready), .op_done(op_done),
    .acc_load_en(acc_load_en), .acc_load_data(acc_load_data),
    .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_rd_data(mem_rd_data), .acc_value(acc_value), .flags(flags)
  );
  alc_word_mem u_mem (
    .core_clk(core_clk), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_rd_data(mem_rd_data)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // 10 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // The whole run needs about a hundred cycles; 3000 means a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("unexpected at %0t: run too long", $time);
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Plain value outputs, widened to 32 bits
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: value %h want %h", $time, got, exp);
    end
  endtask

  // Status flags, zero flag first
  task automatic chk_flags(input alc_flags_t got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: flags %b want %b", $time, got, exp);
    end
  endtask

  // Cycle counts seen by the bench
  task automatic chk_lat(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected at %0t: latency %0d want %0d", $time, got, exp);
    end
  endtask

  // Idle outputs, checked while reset is still held
  task automatic chk_idle();
    chk_val(acc_value, ACC_RST);
    chk_flags(flags, FLAGS_RST);
    chk_val(32'(op_ready), 32'h0000_0001);
    chk_val(32'(op_done), 32'h0000_0000);
    chk_val(32'(mem_rd_en), 32'h0000_0000);
    chk_val(32'(mem_addr), 32'(ADDR_RST));
  endtask

  // Direct load, seen one cycle later
  task automatic load_acc(input logic [31:0] v);
    @(negedge core_clk);
    acc_load_en = 1'b1;
    acc_load_data = v;
    @(negedge core_clk);
    acc_load_en = 1'b0;
    chk_val(acc_value, v);
  endtask

  // One request; ld offers a competing direct load in the take cycle
  task automatic do_op(input alc_row_t t, input bit ld, input int lat);
    int n;
    n = 1;
    @(negedge core_clk);
    chk_val(32'(op_ready), 32'h0000_0001);
    op_valid = 1'b1;
    op_req = '{t.op, t.uc, t.opnd[15:0], t.opnd};
    acc_load_en = ld;
    acc_load_data = 32'hDEAD_BEEF;
    @(negedge core_clk);
    op_valid = 1'b0;
    acc_load_en = 1'b0;
    // Accumulator must not move before the done cycle
    while (op_done !== 1'b1 && n < 20) begin
      chk_val(acc_value, t.acc);
      @(negedge core_clk);
      n++;
    end
    if (lat > 0) chk_lat(n, lat);
    chk_val(acc_value, t.ea);
    chk_flags(flags, t.ef);
  endtask

  // Constant ops 2 cycles, single memory 3, double memory 4
  function automatic int lat_of(input alc_row_t t);
    if (t.uc) return 2;
    if (t.op inside {and_double_op, or_double_op, xor_double_op,
                     compare_double}) return 4;
    return 3;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    op_valid = 1'b0;
    op_req = '0;
    acc_load_en = 1'b0;
    acc_load_data = '0;
    // Flags carry over, so the row order matters
    rows = '{
      '{and_double_op, 0, 32'h0000_0010, 32'hF0F0_FFFF, 32'h10E0_10EF, 5'h00},
      '{and_double_op, 1, 32'h8000_0001, 32'hFFFF_FFFF, 32'h8000_0001, 5'h08},
      '{or_single_op, 0, 32'h0000_0020, 32'hABCD_0100, 32'h0000_21DF, 5'h00},
      '{or_single_op, 1, 32'h1234_0000, 32'hFFFF_0000, 32'h0000_0000, 5'h18},
      '{or_double_op, 0, 32'h0000_0030, 32'h8000_0000, 32'hB1CE_30CF, 5'h08},
      '{xor_single_op, 0, 32'h0000_0040, 32'h5555_40BF, 32'h0000_0000, 5'h18},
      '{xor_double_op, 1, 32'h3647_6A38, 32'h3647_6A38, 32'h0000_0000, 5'h10},
      '{xor_double_op, 0, 32'h0000_00FF, 32'h0000_0000, 32'h00FF_FF00, 5'h00},
      '{compare_single, 0, 32'h0000_0050, 32'hFFFF_50AE, 32'hFFFF_50AE, 5'h04},
      '{compare_double, 1, 32'h0000_0005, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 5'h01},
      '{compare_single, 1, 32'hFFFF_1234, 32'h0000_1234, 32'h0000_1234, 5'h03},
      '{compare_double, 0, 32'h0000_0060, 32'h619E_609F, 32'h619E_609F, 5'h02},
      '{compare_double, 1, 32'h8000_0000, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 5'h04},
      '{and_double_op, 1, 32'h0000_0000, 32'h1234_5678, 32'h0000_0000, 5'h14}
    };
    repeat (6) @(negedge core_clk);
    chk_idle();
    sys_rst = 1'b0;
    // Ordinary cases
    foreach (rows[i]) begin
      load_acc(rows[i].acc);
      do_op(rows[i], 1'b0, lat_of(rows[i]));
    end
    // A direct load offered with a request is ignored
    load_acc(32'h0000_00F0);
    r = '{or_double_op, 1, 32'h0000_000F, 32'h0000_00F0, 32'h0000_00FF, 5'h04};
    do_op(r, 1'b1, 2);
    // Unused code completes with no effect on value or flags
    r = '{alc_op_t'(3'h7), 1, 32'h0000_0000, 32'h0000_00FF, 32'h0000_00FF,
          5'h04};
    // Still answers like any constant op, so a hang shows up here
    do_op(r, 1'b0, 2);
    // Reset in mid-run, then recovery on a single memory op
    @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    chk_idle();
    sys_rst = 1'b0;
    load_acc(rows[5].acc);
    do_op(rows[5], 1'b0, 3);
    summarize();
  end
endmodule
